// *** core/io_line_function_mux.sv ***
`timescale 1ns/1ps
module io_line_function_mux #(
  parameter int                      LINES           = io_line_mux_pkg::LINE_COUNT,
  parameter logic [LINES-1:0]        OWNERSHIP_RESET = io_line_mux_pkg::OWNERSHIP_RESET[LINES-1:0],
  parameter logic [LINES-1:0]        PULL_UP_RESET   = io_line_mux_pkg::PULL_UP_RESET[LINES-1:0],
  parameter logic [LINES-1:0]        PULL_DOWN_RESET = io_line_mux_pkg::PULL_DOWN_RESET[LINES-1:0],
  parameter logic [LINES-1:0]        MUXED_LINES     = io_line_mux_pkg::MUXED_LINES[LINES-1:0],
  parameter logic [4*LINES-1:0]      FUNC_EXISTS     = {(4*LINES){1'b1}}
) (
  input  wire logic                  CLOCK,
  input  wire logic                  RESET_N,
  input  wire logic                  CLOCK_ENABLE,
  input  wire logic [LINES-1:0]      PULL_UP_ENABLE_STROBE,
  input  wire logic [LINES-1:0]      PULL_UP_DISABLE_STROBE,
  input  wire logic [LINES-1:0]      PULL_DOWN_ENABLE_STROBE,
  input  wire logic [LINES-1:0]      PULL_DOWN_DISABLE_STROBE,
  input  wire logic [LINES-1:0]      LINE_OWNERSHIP_ENABLE,
  input  wire logic [LINES-1:0]      LINE_OWNERSHIP_DISABLE,
  input  wire logic                  FUNCTION_SELECT_FIRST_WRITE,
  input  wire logic [LINES-1:0]      FUNCTION_SELECT_FIRST_DATA,
  input  wire logic                  FUNCTION_SELECT_SECOND_WRITE,
  input  wire logic [LINES-1:0]      FUNCTION_SELECT_SECOND_DATA,
  input  wire logic [LINES-1:0]      CONTROLLER_OUT,
  input  wire logic [4*LINES-1:0]    FUNC_OUT,
  input  wire logic [LINES-1:0]      PIN_IN,
  output logic      [LINES-1:0]      PULL_UP_STATUS_N,
  output logic      [LINES-1:0]      PULL_DOWN_STATUS_VECTOR,
  output logic      [LINES-1:0]      LINE_OWNERSHIP_STATUS,
  output logic      [LINES-1:0]      FUNCTION_SELECT_FIRST,
  output logic      [LINES-1:0]      FUNCTION_SELECT_SECOND,
  output logic      [LINES-1:0]      PIN_OUT,
  output logic      [LINES-1:0]      PERIPHERAL_IN
);

  // Set-then-clear with one strobe pair; both high clears
  function automatic logic [LINES-1:0] set_clear(input logic [LINES-1:0] value,
                                                  input logic [LINES-1:0] set,
                                                  input logic [LINES-1:0] clear);
    set_clear = (value | set) & ~clear;
  endfunction : set_clear

  wire logic [LINES-1:0] pull_up_active;
  wire logic [LINES-1:0] pull_down_active;
  wire logic [LINES-1:0] up_set_allowed;
  wire logic [LINES-1:0] down_set_allowed;
  wire logic [LINES-1:0] next_pull_up_status_n;
  wire logic [LINES-1:0] next_pull_down_status;
  wire logic [LINES-1:0] next_ownership;
  wire logic [LINES-1:0] next_first;
  wire logic [LINES-1:0] next_second;
  wire logic [LINES-1:0] next_pin_out;

  ////////////////////////////////////////////////////////////////////////////////
  // Pull resistors: status bit zero means that resistor is on
  assign pull_up_active   = ~PULL_UP_STATUS_N;
  assign pull_down_active = ~PULL_DOWN_STATUS_VECTOR;
  // Simultaneous enable of both on an idle line: neither is blocked by
  // the other's old state, so pull-up wins and pull-down is dropped
  assign up_set_allowed   = PULL_UP_ENABLE_STROBE & ~pull_down_active;
  assign down_set_allowed = PULL_DOWN_ENABLE_STROBE & ~pull_up_active
                            & ~up_set_allowed;
  // Enabling clears the status bit, disabling sets it
  assign next_pull_up_status_n = set_clear(PULL_UP_STATUS_N, PULL_UP_DISABLE_STROBE,
                                           up_set_allowed);
  assign next_pull_down_status = set_clear(PULL_DOWN_STATUS_VECTOR, PULL_DOWN_DISABLE_STROBE,
                                           down_set_allowed);

  ////////////////////////////////////////////////////////////////////////////////
  // Ownership; non-multiplexed lines pinned at one
  assign next_ownership = set_clear(LINE_OWNERSHIP_STATUS, LINE_OWNERSHIP_ENABLE,
                                    LINE_OWNERSHIP_DISABLE & MUXED_LINES) | ~MUXED_LINES;

  // Select vectors are whole-word writes, independent of ownership
  assign next_first  = FUNCTION_SELECT_FIRST_WRITE ? FUNCTION_SELECT_FIRST_DATA
                                                   : FUNCTION_SELECT_FIRST;
  assign next_second = FUNCTION_SELECT_SECOND_WRITE ? FUNCTION_SELECT_SECOND_DATA
                                                    : FUNCTION_SELECT_SECOND;

  ////////////////////////////////////////////////////////////////////////////////
  // Output steering per line
  genvar line;
  generate
    for (line = 0; line < LINES; line++) begin : g_line
      line_output_select u_select (
        .owned_by_controller (LINE_OWNERSHIP_STATUS[line]),
        .select_first        (FUNCTION_SELECT_FIRST[line]),
        .select_second       (FUNCTION_SELECT_SECOND[line]),
        .func_out            (FUNC_OUT[4*line +: 4]),
        .func_exists         (FUNC_EXISTS[4*line +: 4]),
        .controller_out      (CONTROLLER_OUT[line]),
        .next_out            (next_pin_out[line])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      PULL_UP_STATUS_N        <= PULL_UP_RESET;
      PULL_DOWN_STATUS_VECTOR <= PULL_DOWN_RESET;
      LINE_OWNERSHIP_STATUS   <= OWNERSHIP_RESET | ~MUXED_LINES;
      FUNCTION_SELECT_FIRST   <= io_line_mux_pkg::SELECT_RESET[LINES-1:0];
      FUNCTION_SELECT_SECOND  <= io_line_mux_pkg::SELECT_RESET[LINES-1:0];
      PIN_OUT                 <= '0;
      PERIPHERAL_IN           <= '0;
    end else if (CLOCK_ENABLE) begin
      PULL_UP_STATUS_N        <= next_pull_up_status_n;
      PULL_DOWN_STATUS_VECTOR <= next_pull_down_status;
      LINE_OWNERSHIP_STATUS   <= next_ownership;
      FUNCTION_SELECT_FIRST   <= next_first;
      FUNCTION_SELECT_SECOND  <= next_second;
      PIN_OUT                 <= next_pin_out;
      // Registered to keep outputs flop-driven; costs one cycle of latency
      PERIPHERAL_IN           <= PIN_IN;
    end
  end

endmodule : io_line_function_mux

// *** core/io_line_mux_pkg.sv ***
package io_line_mux_pkg;

  // Default line count of one controller
  localparam int LINE_COUNT = 32;

  // Function choice codes: {second, first}
  typedef enum logic [1:0] {
    FUNC_A = 2'h0,
    FUNC_B = 2'h1,
    FUNC_C = 2'h2,
    FUNC_D = 2'h3
  } function_type;

  // Values after reset, and the mask of multiplexed lines
  localparam logic [31:0] OWNERSHIP_RESET    = 32'hFFFFFFFF;
  localparam logic [31:0] PULL_UP_RESET      = 32'hFFFFFFFF;
  localparam logic [31:0] PULL_DOWN_RESET    = 32'hFFFFFFFF;
  localparam logic [31:0] MUXED_LINES        = 32'hFFFFFFFF;
  localparam logic [31:0] SELECT_RESET       = 32'h00000000;

endpackage : io_line_mux_pkg

// *** core/line_output_select.sv ***
`timescale 1ns/1ps
module line_output_select (
  input  wire logic       owned_by_controller,
  input  wire logic       select_first,
  input  wire logic       select_second,
  input  wire logic [3:0] func_out,
  input  wire logic [3:0] func_exists,
  input  wire logic       controller_out,
  output logic            next_out
);

  wire io_line_mux_pkg::function_type choice;
  wire logic                          func_level;

  assign choice     = io_line_mux_pkg::function_type'({select_second, select_first});
  // Missing function leaves the line undriven by any peripheral (low)
  assign func_level = func_exists[choice] & func_out[choice];
  assign next_out   = owned_by_controller ? controller_out : func_level;

endmodule : line_output_select

// *** tb/io_line_props.sv ***
`timescale 1ns/1ps
module io_line_props #(
  parameter int               LINES       = 4,
  parameter logic [LINES-1:0] MUXED_LINES = '1
) (
  input wire logic             CLOCK,
  input wire logic             RESET_N,
  input wire logic             CLOCK_ENABLE,
  input wire logic [LINES-1:0] PULL_UP_ENABLE_STROBE,
  input wire logic [LINES-1:0] PULL_DOWN_ENABLE_STROBE,
  input wire logic [LINES-1:0] LINE_OWNERSHIP_ENABLE,
  input wire logic [LINES-1:0] LINE_OWNERSHIP_DISABLE,
  input wire logic             FUNCTION_SELECT_FIRST_WRITE,
  input wire logic [LINES-1:0] FUNCTION_SELECT_FIRST_DATA,
  input wire logic [LINES-1:0] PIN_IN,
  input wire logic [LINES-1:0] PULL_UP_STATUS_N,
  input wire logic [LINES-1:0] PULL_DOWN_STATUS_VECTOR,
  input wire logic [LINES-1:0] LINE_OWNERSHIP_STATUS,
  input wire logic [LINES-1:0] FUNCTION_SELECT_FIRST,
  input wire logic [LINES-1:0] PERIPHERAL_IN
);
  // Pull-up enable beats pull-down enable on an idle line
  wire [LINES-1:0] pu_ok  = PULL_UP_ENABLE_STROBE & PULL_DOWN_STATUS_VECTOR;
  wire [LINES-1:0] pd_ok  = PULL_DOWN_ENABLE_STROBE & PULL_UP_STATUS_N & ~PULL_UP_ENABLE_STROBE;
  wire [LINES-1:0] pd_bad = PULL_DOWN_ENABLE_STROBE & ~PULL_UP_STATUS_N;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  sequence s_release;
    CLOCK_ENABLE && |LINE_OWNERSHIP_DISABLE;
  endsequence
  a_pull_never_both: assert property ((PULL_UP_STATUS_N | PULL_DOWN_STATUS_VECTOR) == '1)
    else $error("both pulls on");
  a_pu_taken: assert property (CLOCK_ENABLE && |pu_ok |=> (PULL_UP_STATUS_N & $past(pu_ok)) == '0)
    else $error("pull-up enable lost");
  a_pd_taken: assert property (CLOCK_ENABLE && |pd_ok |=> (PULL_DOWN_STATUS_VECTOR & $past(pd_ok)) == '0)
    else $error("pull-down enable lost");
  a_pd_dropped: assert property (|pd_bad |=> (PULL_DOWN_STATUS_VECTOR & $past(pd_bad)) == $past(pd_bad))
    else $error("pull-down taken under pull-up");
  a_own_release: assert property (s_release |=> (LINE_OWNERSHIP_STATUS & $past(LINE_OWNERSHIP_DISABLE) & MUXED_LINES) == '0)
    else $error("line not released");
  a_own_fixed: assert property ((LINE_OWNERSHIP_STATUS | MUXED_LINES) == '1)
    else $error("plain line released");
  a_own_hold: assert property (!(|{LINE_OWNERSHIP_ENABLE, LINE_OWNERSHIP_DISABLE}) |=> $stable(LINE_OWNERSHIP_STATUS))
    else $error("ownership moved unasked");
  a_sel_load: assert property (CLOCK_ENABLE && FUNCTION_SELECT_FIRST_WRITE |=> FUNCTION_SELECT_FIRST == $past(FUNCTION_SELECT_FIRST_DATA))
    else $error("select not loaded");
  a_input_follow: assert property (CLOCK_ENABLE |=> PERIPHERAL_IN == $past(PIN_IN))
    else $error("peripheral input cut");
endmodule : io_line_props
////////////////////////////////////////////////////////////////////////////////
bind io_line_function_mux io_line_props #(.LINES(LINES), .MUXED_LINES(MUXED_LINES)) u_props (.*);

// *** tb/func_partner.sv ***
`timescale 1ns/1ps
module func_partner #(
  parameter int LINES = 4
) (
  input  wire logic [LINES-1:0]   PIN_OUT,
  input  wire logic [LINES-1:0]   FLIP,
  input  wire logic [4*LINES-1:0] FUNC_PAT,
  output logic      [4*LINES-1:0] FUNC_OUT,
  output logic      [LINES-1:0]   PIN_IN
);
  // Distinct level per function, so a wrong pick shows at the pin
  assign FUNC_OUT = FUNC_PAT;
  // Pad echoes its own drive; flip stands for an outside driver
  assign PIN_IN   = PIN_OUT ^ FLIP;
endmodule : func_partner

// *** tb/test_io_line_function_mux.sv ***
`timescale 1ns/1ps
module test_io_line_function_mux;
  logic CLOCK = 1'b0, RESET_N = 1'b0, CLOCK_ENABLE = 1'b1;
  logic FUNCTION_SELECT_FIRST_WRITE = 1'b0, FUNCTION_SELECT_SECOND_WRITE = 1'b0;
  logic [3:0] PULL_UP_ENABLE_STROBE = 4'h0, PULL_UP_DISABLE_STROBE = 4'h0;
  logic [3:0] PULL_DOWN_ENABLE_STROBE = 4'h0, PULL_DOWN_DISABLE_STROBE = 4'h0;
  logic [3:0] LINE_OWNERSHIP_ENABLE = 4'h0, LINE_OWNERSHIP_DISABLE = 4'h0;
  logic [3:0] FUNCTION_SELECT_FIRST_DATA = 4'h0, FUNCTION_SELECT_SECOND_DATA = 4'h0;
  logic [3:0] CONTROLLER_OUT = 4'hF, FLIP = 4'h0, PIN_IN, PIN_OUT, PERIPHERAL_IN, exp_pin;
  logic [3:0] PULL_UP_STATUS_N, PULL_DOWN_STATUS_VECTOR, LINE_OWNERSHIP_STATUS;
  logic [3:0] FUNCTION_SELECT_FIRST, FUNCTION_SELECT_SECOND;
  logic [15:0] FUNC_OUT, FUNC_PAT = 16'h0D60;
  int error_cnt = 0, compares = 0;
  // Line 3 plain, line 2 lacks function D, mixed reset states
  io_line_function_mux #(.LINES(4), .OWNERSHIP_RESET(4'hE), .PULL_UP_RESET(4'hD),
    .PULL_DOWN_RESET(4'hB), .MUXED_LINES(4'h7), .FUNC_EXISTS(16'hF7FF)) u_dut (.*);
  func_partner u_far (.*);
  initial begin
    forever #12.5 CLOCK = ~CLOCK;
  end
  ////////////////////////////////////////////////////////////////////////////
  task step(input int n);
    repeat (n) @(posedge CLOCK);
    #2;
    {PULL_UP_ENABLE_STROBE, PULL_UP_DISABLE_STROBE, PULL_DOWN_ENABLE_STROBE} = 12'h000;
    {PULL_DOWN_DISABLE_STROBE, LINE_OWNERSHIP_ENABLE, LINE_OWNERSHIP_DISABLE} = 12'h000;
    {FUNCTION_SELECT_FIRST_WRITE, FUNCTION_SELECT_SECOND_WRITE} = 2'h0;
  endtask : step
  task chk(input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task end_sim;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    step(20);
    RESET_N = 1'b1;
    chk(PULL_UP_STATUS_N, 4'hD);
    chk(PULL_DOWN_STATUS_VECTOR, 4'hB);
    chk(LINE_OWNERSHIP_STATUS, 4'hE);
    chk(FUNCTION_SELECT_FIRST | FUNCTION_SELECT_SECOND, 4'h0);
    PULL_UP_ENABLE_STROBE = 4'hF;
    step(1);
    chk(PULL_UP_STATUS_N, 4'h4);
    PULL_DOWN_ENABLE_STROBE = 4'hF;
    step(1);
    chk(PULL_DOWN_STATUS_VECTOR, 4'hB);
    PULL_UP_DISABLE_STROBE = 4'hF;
    step(1);
    PULL_DOWN_ENABLE_STROBE = 4'h3;
    step(1);
    chk(PULL_DOWN_STATUS_VECTOR, 4'h8);
    {LINE_OWNERSHIP_ENABLE, LINE_OWNERSHIP_DISABLE} = 8'hFE;
    step(1);
    chk(LINE_OWNERSHIP_STATUS, 4'h9);
    for (int k = 0; k < 4; k++) begin
      {FUNCTION_SELECT_FIRST_WRITE, FUNCTION_SELECT_SECOND_WRITE} = 2'h3;
      FUNCTION_SELECT_FIRST_DATA = {4{k[0]}};
      FUNCTION_SELECT_SECOND_DATA = {4{k[1]}};
      exp_pin = {1'b1, FUNC_PAT[8+k] & (k != 3), FUNC_PAT[4+k], 1'b1};
      step(1);
      chk({FUNCTION_SELECT_SECOND[1], FUNCTION_SELECT_FIRST[1]}, k[1:0]);
      step(1);
      chk(PIN_OUT, exp_pin);
    end
    FLIP = 4'h6;
    step(2);
    chk(PERIPHERAL_IN, exp_pin ^ 4'h6);
    // Frozen clock enable must hold a disable strobe off
    CLOCK_ENABLE = 1'b0;
    PULL_DOWN_DISABLE_STROBE = 4'hF;
    step(1);
    chk(PULL_DOWN_STATUS_VECTOR, 4'h8);
    CLOCK_ENABLE = 1'b1;
    PULL_DOWN_DISABLE_STROBE = 4'hF;
    step(1);
    chk(PULL_DOWN_STATUS_VECTOR, 4'hF);
    end_sim;
  end
  initial begin
    repeat (500) @(posedge CLOCK);
    error_cnt++;
    end_sim;
  end
endmodule : test_io_line_function_mux
